// >>> twd_timer_watchdog.sv
// Timer/watchdog unit: prescaler, 16-bit down-counter, input modes, output and routing.
// Assumes pins are synchronous to pclk except the count input, which is synchronised here.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module twd_timer_watchdog
    import twd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_count_input,
    input  wire logic        external_interrupt_line_zero,
    input  wire logic        top_level_pin,
    input  wire logic        hw_sw_watchdog_strap,
    output logic             waveform_output,
    output logic             top_level_irq,
    output logic             channel_a0_irq,
    output logic             system_reset_req
);
    import twd_pkg::*;

    logic [7:0]  ctrl_ff;
    logic [15:0] const_ff;
    logic [7:0]  pre_ff;
    logic [2:0]  cfg_ff;
    logic [15:0] cnt_ff;
    logic [7:0]  pre_cnt_ff;
    logic [1:0]  div_ff;
    logic        pend_ff;
    logic        armed_ff;
    logic        key_ff;
    logic        strap_done_ff;
    logic        strap_hw_ff;
    logic        sync1_ff;
    logic        sync2_ff;
    logic        prev_ff;
    logic        toggle_ff;
    logic        wave_ff;
    logic        top_ff;
    logic        a0_ff;
    logic        rst_req_ff;
    logic        wdg_prev_ff;
    logic [31:0] nxt_prdata;

    logic        acc;
    logic        wr;
    logic        wr_ctrl;
    logic        wr_const;
    logic        wr_pre;
    logic        wdg;
    logic        run_eff;
    logic        tick4;
    logic        fall;
    logic        src;
    logic        src_pulse;
    logic        cnt_tick;
    logic        eoc;
    logic        start_ev;
    logic        kick;
    logic        retrig;
    logic        wdg_start;
    logic        reload;
    twd_inmode_t mode;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // Zero-wait slave: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign acc     = psel & penable;
    assign wr      = acc & pwrite;
    assign pslverr = acc & ~(hit(paddr, TWD_OFS_CTRL) | hit(paddr, TWD_OFS_HIGH) |
                             hit(paddr, TWD_OFS_LOW) | hit(paddr, TWD_OFS_PRE) |
                             hit(paddr, TWD_OFS_CFG) | hit(paddr, TWD_OFS_STAT));
    assign wr_ctrl  = wr & hit(paddr, TWD_OFS_CTRL);
    assign wr_pre   = wr & hit(paddr, TWD_OFS_PRE);
    // Constant is frozen once the watchdog runs; low writes then carry the key
    assign wr_const = wr & ~wdg & (hit(paddr, TWD_OFS_HIGH) | hit(paddr, TWD_OFS_LOW));

    assign wdg     = ~cfg_ff[TWD_B_WDEN_LOW] | strap_hw_ff; // [R21]
    assign run_eff = wdg | ctrl_ff[TWD_B_RUN]; // [R7]
    assign mode    = twd_inmode_t'({ctrl_ff[TWD_B_MODE_HI], ctrl_ff[TWD_B_MODE_LO]});
    assign tick4   = (div_ff == TWD_DIV_LAST);
    assign fall    = prev_ff & ~sync2_ff; // [R27]

    // Watchdog ignores input mode and always runs on clock/4
    always_comb begin
        src = tick4;
        if (!wdg && ctrl_ff[TWD_B_INPUT_ENABLE_BIT]) begin // [R12]
            case (mode)
                IM_EVENT:  src = fall; // [R13]
                IM_GATED:  src = tick4 & sync2_ff; // [R15]
                IM_TRIG:   src = tick4 & armed_ff; // [R16]
                IM_RETRIG: src = tick4; // [R17]
                default:   src = tick4;
            endcase
        end
    end

    assign src_pulse = run_eff & src; // [R3]
    assign cnt_tick  = src_pulse & (pre_cnt_ff == 8'h00); // [R26]
    assign eoc       = cnt_tick & (cnt_ff == 16'h0000); // [R6]
    assign start_ev  = wr_ctrl & pwdata[TWD_B_RUN] & ~ctrl_ff[TWD_B_RUN] & ~wdg;
    assign kick      = wdg & key_ff & wr & hit(paddr, TWD_OFS_LOW) & (pwdata[7:0] == TWD_KEY_FIRE);
    assign retrig    = ~wdg & ctrl_ff[TWD_B_INPUT_ENABLE_BIT] & (mode == IM_RETRIG) & ctrl_ff[TWD_B_RUN] & fall;
    assign wdg_start = wdg & ~wdg_prev_ff;
    assign reload    = kick | retrig | wdg_start | (start_ev & pend_ff) | eoc;

    // Strap caught once after reset release; a later change has no effect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_done_ff <= 1'b0;
            strap_hw_ff   <= 1'b0;
        end else if (!strap_done_ff) begin
            strap_done_ff <= 1'b1;
            strap_hw_ff   <= ~hw_sw_watchdog_strap; // [R21]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            prev_ff  <= 1'b1;
        end else begin
            sync1_ff <= external_count_input; // [R27]
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 2'h0;
        end else begin
            div_ff <= div_ff + 2'h1; // [R2]
        end
    end

    // Software write wins over the hardware clear of run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= TWD_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_ff <= pwdata[7:0]; // [R8]
        end else if (eoc && ctrl_ff[TWD_B_SINGLE] && !wdg) begin
            ctrl_ff[TWD_B_RUN] <= 1'b0; // [R9]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            const_ff <= TWD_RST_CONST; // [R22]
        end else if (wr_const && hit(paddr, TWD_OFS_HIGH)) begin
            const_ff[15:8] <= pwdata[7:0];
        end else if (wr_const) begin
            const_ff[7:0] <= pwdata[7:0];
        end
    end

    // Pending flag: a write in the same cycle as a load wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff <= 1'b0;
        end else if (wr_const) begin
            pend_ff <= 1'b1; // [R5]
        end else if (reload) begin
            pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= TWD_RST_PRE; // [R22]
        end else if (wr_pre) begin
            pre_ff <= pwdata[7:0];
        end
    end

    // Only one-way: once cleared the watchdog cannot be switched off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= TWD_RST_CFG;
        end else if (wr && hit(paddr, TWD_OFS_CFG)) begin
            cfg_ff[TWD_B_TOP_SEL:TWD_B_A0_SEL] <= pwdata[TWD_B_TOP_SEL:TWD_B_A0_SEL];
            cfg_ff[TWD_B_WDEN_LOW] <= cfg_ff[TWD_B_WDEN_LOW] & pwdata[TWD_B_WDEN_LOW];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdg_prev_ff <= 1'b0;
        end else begin
            wdg_prev_ff <= wdg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_ff <= 1'b0;
        end else if (wdg && wr && hit(paddr, TWD_OFS_LOW)) begin
            key_ff <= (pwdata[7:0] == TWD_KEY_ARM); // [R24]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_ff <= 1'b0;
        end else if (!ctrl_ff[TWD_B_RUN]) begin
            armed_ff <= 1'b0;
        end else if (fall) begin
            armed_ff <= 1'b1; // [R16]
        end
    end

    // New prescale value takes over the running division at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_ff <= TWD_RST_PRE;
        end else if (wr_pre) begin
            pre_cnt_ff <= pwdata[7:0]; // [R5]
        end else if (kick || retrig || wdg_start) begin
            pre_cnt_ff <= pre_ff;
        end else if (cnt_tick) begin
            pre_cnt_ff <= pre_ff; // [R26]
        end else if (src_pulse) begin
            pre_cnt_ff <= pre_cnt_ff - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= TWD_RST_CONST;
        end else if (kick || retrig || wdg_start) begin
            cnt_ff <= const_ff; // [R24] [R17]
        end else if (start_ev && pend_ff) begin
            cnt_ff <= const_ff; // [R10] [R4]
        end else if (eoc) begin
            cnt_ff <= const_ff; // [R11] [R9]
        end else if (cnt_tick) begin
            cnt_ff <= cnt_ff - 16'h0001; // [R1]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            toggle_ff <= 1'b0;
        end else if (eoc) begin
            toggle_ff <= ~toggle_ff; // [R19]
        end
    end

    // Level style holds between terminal counts, so software may change the bit freely
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_ff <= 1'b1;
        end else if (!ctrl_ff[TWD_B_OUTPUT_ENABLE_BIT]) begin
            wave_ff <= 1'b1; // [R18]
        end else if (eoc && ctrl_ff[TWD_B_STYLE]) begin
            wave_ff <= ctrl_ff[TWD_B_LEVEL]; // [R23]
        end else if (eoc) begin
            wave_ff <= ~toggle_ff; // [R19]
        end else if (!ctrl_ff[TWD_B_STYLE]) begin
            wave_ff <= toggle_ff;
        end
    end
    assign waveform_output = wave_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            top_ff     <= 1'b0;
            a0_ff      <= 1'b0;
            rst_req_ff <= 1'b0;
        end else begin
            top_ff     <= cfg_ff[TWD_B_TOP_SEL] ? top_level_pin : (eoc & ~wdg); // [R20]
            a0_ff      <= cfg_ff[TWD_B_A0_SEL] ? external_interrupt_line_zero : (eoc & ~wdg); // [R20]
            rst_req_ff <= eoc & wdg; // [R25]
        end
    end
    assign top_level_irq    = top_ff;
    assign channel_a0_irq   = a0_ff;
    assign system_reset_req = rst_req_ff;

    // Count registers read the live counter, not the stored constant
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (acc && !pwrite) begin
            case (paddr)
                TWD_OFS_CTRL: nxt_prdata[7:0] = ctrl_ff;
                TWD_OFS_HIGH: nxt_prdata[7:0] = cnt_ff[15:8];
                TWD_OFS_LOW:  nxt_prdata[7:0] = cnt_ff[7:0];
                TWD_OFS_PRE:  nxt_prdata[7:0] = pre_ff;
                TWD_OFS_CFG:  nxt_prdata[2:0] = cfg_ff;
                TWD_OFS_STAT: nxt_prdata[2:0] = {pend_ff, strap_hw_ff, wdg};
                default:      nxt_prdata = 32'h0000_0000;
            endcase
        end
    end
    assign prdata = nxt_prdata;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_dec;
        cnt_tick && (cnt_ff != 16'h0000) && !reload |=> cnt_ff == $past(cnt_ff) - 16'h0001;
    endproperty
    a_dec: assert property (p_dec) else $error("counter did not step down"); // [R1]

    property p_div4;
        tick4 |=> !tick4 [*3] ##1 tick4;
    endproperty
    a_div4: assert property (p_div4) else $error("clock/4 enable wrong"); // [R2]

    property p_hold;
        !run_eff && !reload |=> $stable(cnt_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("stopped counter moved"); // [R4]

    property p_pre_now;
        wr_pre |=> pre_cnt_ff == $past(pwdata[7:0]);
    endproperty
    a_pre_now: assert property (p_pre_now) else $error("prescale not immediate"); // [R5]

    property p_reload;
        eoc |=> cnt_ff == $past(const_ff);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload at terminal count"); // [R11]

    property p_single;
        eoc && ctrl_ff[TWD_B_SINGLE] && !wdg && !wr_ctrl |=> !ctrl_ff[TWD_B_RUN];
    endproperty
    a_single: assert property (p_single) else $error("single mode kept running"); // [R9]

    property p_gate;
        !wdg && ctrl_ff[TWD_B_INPUT_ENABLE_BIT] && (mode == IM_GATED) && !sync2_ff |-> !src_pulse;
    endproperty
    a_gate: assert property (p_gate) else $error("gated mode counted while low"); // [R15]

    property p_off;
        !ctrl_ff[TWD_B_OUTPUT_ENABLE_BIT] |=> waveform_output;
    endproperty
    a_off: assert property (p_off) else $error("disabled output not high"); // [R18]

    property p_toggle;
        eoc && ctrl_ff[TWD_B_OUTPUT_ENABLE_BIT] && !ctrl_ff[TWD_B_STYLE] ##1 ctrl_ff[TWD_B_OUTPUT_ENABLE_BIT]
            |-> waveform_output != $past(waveform_output);
    endproperty
    a_toggle: assert property (p_toggle) else $error("square wave missed a toggle"); // [R19]

    property p_wdg_rst;
        eoc && wdg |=> system_reset_req ##1 !system_reset_req || $past(eoc);
    endproperty
    a_wdg_rst: assert property (p_wdg_rst) else $error("watchdog expiry without reset"); // [R25]

    property p_kick;
        kick |=> cnt_ff == $past(const_ff) && pre_cnt_ff == $past(pre_ff);
    endproperty
    a_kick: assert property (p_kick) else $error("key sequence did not reload"); // [R24]

    property p_strap;
        strap_hw_ff && tick4 && !wr_pre && !reload |=> pre_cnt_ff != $past(pre_cnt_ff) || cnt_ff != $past(cnt_ff);
    endproperty
    a_strap: assert property (p_strap) else $error("strap did not force watchdog"); // [R21]
endmodule
`default_nettype wire

// >>> twd_pkg.sv
// Constants, register map and types of the timer/watchdog unit.
// Assumes a 32-bit APB slave port and one 200 MHz clock.
// Functional notes
// [R1] A 16-bit down-counter is decremented by the output of an 8-bit prescaler.
// [R2] The count source is the external input or the internal clock divided by four.
// [R3] Setting the run bit starts counting next cycle; clearing it stops counting.
// [R4] A restart resumes from the held value unless a new constant was written.
// [R5] A new constant waits for terminal count; a new prescale value acts at once.
// [R6] Terminal count is the counter standing at zero when a count arrives.
// [R7] In watchdog mode the run bit does not gate counting.
// [R8] The single/continuous bit is writable anytime, together with the run bit.
// [R9] Single mode: terminal count stops, reloads the constant and clears run.
// [R10] Single mode: a constant changed while stopped is loaded on restart.
// [R11] Continuous mode: each terminal count reloads the constant and keeps counting.
// [R12] Input enable selects external input pulses, else internal clock divided by four.
// [R13] Event mode: each falling edge of the input is one count while running.
// [R14] The source keeps falling edges at least eight clock periods apart.
// [R15] Gated mode: count at clock/4 only while running and the input is high.
// [R16] Triggerable mode: clock/4 counting starts at a falling edge after run is set.
// [R17] Retriggerable mode: falling edges while running reload the constant.
// [R18] Output disabled drives the waveform output high.
// [R19] Square-wave style toggles the waveform output at each terminal count.
// [R20] Timer terminal count routes to the top-level or the channel A0 interrupt.
// [R21] A strap held low at reset forces watchdog mode permanently.
// [R22] Software loads prescale and constant before starting, else reset values count.
// [R23] Level style copies the output level bit to the output at terminal count.
// [R24] Watchdog: writing AAh then 55h to the low count register reloads and restarts.
// [R25] Watchdog terminal count raises a system reset request.
// [R26] A prescale value n divides by n plus one.
// [R27] The external input is synchronised before edge detection.
package twd_pkg;
    localparam logic [7:0]  TWD_OFS_CTRL   = 8'h00;
    localparam logic [7:0]  TWD_OFS_HIGH   = 8'h04;
    localparam logic [7:0]  TWD_OFS_LOW    = 8'h08;
    localparam logic [7:0]  TWD_OFS_PRE    = 8'h0C;
    localparam logic [7:0]  TWD_OFS_CFG    = 8'h10;
    localparam logic [7:0]  TWD_OFS_STAT   = 8'h14;
    localparam logic [7:0]  TWD_RST_CTRL   = 8'h12;
    localparam logic [15:0] TWD_RST_CONST  = 16'hFFFF;
    localparam logic [7:0]  TWD_RST_PRE    = 8'hFF;
    localparam logic [2:0]  TWD_RST_CFG    = 3'h7;
    localparam int          TWD_B_RUN      = 7;
    localparam int          TWD_B_SINGLE   = 6;
    localparam int          TWD_B_MODE_HI  = 5;
    localparam int          TWD_B_MODE_LO  = 4;
    localparam int          TWD_B_INPUT_ENABLE_BIT     = 3;
    localparam int          TWD_B_STYLE    = 2;
    localparam int          TWD_B_LEVEL    = 1;
    localparam int          TWD_B_OUTPUT_ENABLE_BIT    = 0;
    localparam int          TWD_B_WDEN_LOW = 0;
    localparam int          TWD_B_A0_SEL   = 1;
    localparam int          TWD_B_TOP_SEL  = 2;
    localparam logic [7:0]  TWD_KEY_ARM    = 8'hAA;
    localparam logic [7:0]  TWD_KEY_FIRE   = 8'h55;
    localparam logic [1:0]  TWD_DIV_LAST   = 2'h3;
    typedef enum logic [1:0] {IM_EVENT, IM_GATED, IM_TRIG, IM_RETRIG} twd_inmode_t;
endpackage

// >>> twd_count_source.sv
// Count source model: drives the external count input with single falling edges on request.
// Assumes the bench pulses fire for one cycle and waits for busy to drop before the next edge.
`timescale 1ns/1ps
`default_nettype none
module twd_count_source #(
    parameter int GAP = 10
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic fire,
    input  wire logic hold_low,
    output logic      line,
    output logic      busy
);
    logic [4:0] gap_ff;

    // Each edge owns a full gap, so falling edges never come closer than the limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_ff <= 5'h00;
        end else if (fire && gap_ff == 5'h00) begin
            gap_ff <= 5'(GAP);
        end else if (gap_ff != 5'h00) begin
            gap_ff <= gap_ff - 5'h01;
        end
    end

    // Idle high, so only a requested pulse or hold_low makes a falling edge
    assign line = hold_low ? 1'b0 : !(gap_ff > 5'(GAP / 2));
    assign busy = (gap_ff != 5'h00);
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench of the timer/watchdog unit: registers, counting, output, routing, watchdog.
// Assumes zero-wait APB answers and a count source model on the external count input.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import twd_pkg::*;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic x;} twd_row_t;
    logic        pclk, presetn, psel, penable, pwrite, fire, hold_low, ext_line, top_pin, strap;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, va;
    logic        pready, pslverr, err, cnt_line, busy, wave, top_irq, a0_irq, rst_req, w0;
    int          failures, checks_done, top_n, a0_n, rst_n, cyc, top_seen;
    twd_row_t    rows [8];

    twd_timer_watchdog u_twd_timer_watchdog (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_input(cnt_line), .external_interrupt_line_zero(ext_line), .top_level_pin(top_pin),
        .hw_sw_watchdog_strap(strap), .waveform_output(wave), .top_level_irq(top_irq),
        .channel_a0_irq(a0_irq), .system_reset_req(rst_req));
    twd_count_source u_twd_count_source (.pclk(pclk), .presetn(presetn), .fire(fire), .hold_low(hold_low),
        .line(cnt_line), .busy(busy));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Pulse tallies; read at an edge they hold the count up to the previous edge
    always @(posedge pclk) begin
        top_n <= top_n + int'(top_irq === 1'b1);
        a0_n  <= a0_n + int'(a0_irq === 1'b1);
        rst_n <= rst_n + int'(rst_req === 1'b1);
    end

    task automatic complete_run;
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic ch(input logic [31:0] s, input logic [31:0] e, input string m);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, m, s, e);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic int cnt_of(input int s);
        return (s == 0) ? top_n : rst_n;
    endfunction

    task automatic wait_cnt(input int s, input int tgt, input int lim);
        for (cyc = 0; cyc < lim && cnt_of(s) < tgt; cyc++) @(posedge pclk);
        ch(32'(cnt_of(s) >= tgt), 32'h1, "expected pulse missing");
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            fire <= 1'b1;
            @(posedge pclk);
            fire <= 1'b0;
            @(posedge pclk);
            while (busy === 1'b1) @(posedge pclk);
        end
    endtask

    initial begin
        #100000;
        failures++;
        complete_run();
    end

    initial begin
        {presetn, psel, penable, pwrite, fire, hold_low, ext_line, top_pin} = 8'h00;
        strap = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        failures = 0;
        checks_done = 0;
        rows = '{'{TWD_OFS_CTRL, 1'h0, 32'h0, 32'h12, 1'h0}, '{TWD_OFS_HIGH, 1'h0, 32'h0, 32'hFF, 1'h0},
                 '{TWD_OFS_LOW, 1'h0, 32'h0, 32'hFF, 1'h0}, '{TWD_OFS_PRE, 1'h0, 32'h0, 32'hFF, 1'h0},
                 '{TWD_OFS_CFG, 1'h0, 32'h0, 32'h07, 1'h0}, '{TWD_OFS_PRE, 1'h1, 32'h5A, 32'h5A, 1'h0},
                 '{8'h18, 1'h1, 32'hFF, 32'h0, 1'h1}, '{TWD_OFS_CFG, 1'h1, 32'h01, 32'h01, 1'h0}};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            if (rows[i].w) xfer(rows[i].a, 1'b1, rows[i].d);
            xfer(rows[i].a, 1'b0, 32'h0);
            ch(rd, rows[i].e, "register read");
            ch(32'(err), 32'(rows[i].x), "slave error flag");
        end
        // Routing of the outside lines when selected
        xfer(TWD_OFS_CFG, 1'b1, 32'h07);
        top_pin <= 1'b1;
        ext_line <= 1'b1;
        repeat (3) @(posedge pclk);
        ch({top_irq, a0_irq}, 2'h3, "outside lines not routed");
        top_pin <= 1'b0;
        ext_line <= 1'b0;
        xfer(TWD_OFS_CFG, 1'b1, 32'h01);
        top_seen = top_n;
        // Single run on clock/4, square wave
        xfer(TWD_OFS_PRE, 1'b1, 32'h00);
        xfer(TWD_OFS_HIGH, 1'b1, 32'h00);
        xfer(TWD_OFS_LOW, 1'b1, 32'h03);
        xfer(TWD_OFS_CTRL, 1'b1, 32'h41);
        xfer(TWD_OFS_CTRL, 1'b1, 32'hC1);
        // Square-wave level settled well before the first terminal count
        w0 = wave;
        wait_cnt(0, top_seen + 1, 40);
        ch(32'(cyc <= 20), 32'h1, "first terminal count late");
        ch(32'(a0_n), 32'(top_seen + 1), "channel interrupt missing");
        ch(32'(wave), 32'(!w0), "square wave did not toggle");
        xfer(TWD_OFS_CTRL, 1'b0, 32'h0);
        ch(rd, 32'h41, "run bit not cleared");
        xfer(TWD_OFS_LOW, 1'b0, 32'h0);
        ch(rd, 32'h03, "constant not reloaded");
        repeat (40) @(posedge pclk);
        ch(32'(top_n), 32'(top_seen + 1), "single run kept going");
        // Continuous run, level copy style
        xfer(TWD_OFS_CTRL, 1'b1, 32'h87);
        wait_cnt(0, top_seen + 2, 40);
        ch(32'(wave), 32'h1, "level copy high");
        xfer(TWD_OFS_CTRL, 1'b1, 32'h85);
        wait_cnt(0, top_seen + 3, 40);
        wait_cnt(0, top_seen + 4, 40);
        ch(32'(cyc), 32'd16, "continuous period");
        ch(32'(wave), 32'h0, "level copy low");
        xfer(TWD_OFS_CTRL, 1'b1, 32'h04);
        // Output flop updates at the edge the task returns on
        @(posedge pclk);
        ch(32'(wave), 32'h1, "disabled output not high");
        xfer(TWD_OFS_LOW, 1'b0, 32'h0);
        va = rd;
        repeat (20) @(posedge pclk);
        xfer(TWD_OFS_LOW, 1'b0, 32'h0);
        ch(rd, va, "stopped counter moved");
        // Event counting through the count source
        xfer(TWD_OFS_LOW, 1'b1, 32'h0A);
        xfer(TWD_OFS_CTRL, 1'b1, 32'h88);
        pulse(3);
        xfer(TWD_OFS_LOW, 1'b0, 32'h0);
        ch(rd, 32'h07, "event count");
        xfer(TWD_OFS_CTRL, 1'b1, 32'h08);
        pulse(2);
        xfer(TWD_OFS_CTRL, 1'b1, 32'h88);
        pulse(1);
        xfer(TWD_OFS_LOW, 1'b0, 32'h0);
        ch(rd, 32'h06, "resume after stop");
        // Triggerable: waits for an edge after run
        // Stop first: a constant written while running waits for terminal count
        xfer(TWD_OFS_CTRL, 1'b1, 32'h28);
        xfer(TWD_OFS_LOW, 1'b1, 32'h40);
        xfer(TWD_OFS_CTRL, 1'b1, 32'hA8);
        repeat (20) @(posedge pclk);
        xfer(TWD_OFS_LOW, 1'b0, 32'h0);
        ch(rd, 32'h40, "counted before trigger");
        pulse(1);
        repeat (20) @(posedge pclk);
        xfer(TWD_OFS_LOW, 1'b0, 32'h0);
        ch(32'(rd < 32'h40), 32'h1, "no count after trigger");
        // Gated: input low halts, high counts
        hold_low <= 1'b1;
        xfer(TWD_OFS_CTRL, 1'b1, 32'h98);
        xfer(TWD_OFS_LOW, 1'b0, 32'h0);
        va = rd;
        repeat (20) @(posedge pclk);
        xfer(TWD_OFS_LOW, 1'b0, 32'h0);
        ch(rd, va, "gate low still counted");
        hold_low <= 1'b0;
        repeat (20) @(posedge pclk);
        xfer(TWD_OFS_LOW, 1'b0, 32'h0);
        ch(32'(rd < va), 32'h1, "gate high did not count");
        // Retriggerable: an edge restarts from the constant
        xfer(TWD_OFS_CTRL, 1'b1, 32'hB8);
        repeat (40) @(posedge pclk);
        xfer(TWD_OFS_LOW, 1'b0, 32'h0);
        va = rd;
        pulse(1);
        xfer(TWD_OFS_LOW, 1'b0, 32'h0);
        ch(32'(rd > va), 32'h1, "retrigger did not reload");
        // Software watchdog: kicks hold off the reset, then it fires
        xfer(TWD_OFS_CTRL, 1'b1, 32'h00);
        xfer(TWD_OFS_LOW, 1'b1, 32'h03);
        top_seen = top_n;
        xfer(TWD_OFS_CFG, 1'b1, 32'h00);
        repeat (6) begin
            xfer(TWD_OFS_LOW, 1'b1, {24'h0, TWD_KEY_ARM});
            xfer(TWD_OFS_LOW, 1'b1, {24'h0, TWD_KEY_FIRE});
        end
        ch(32'(rst_n), 32'h0, "reset despite kicks");
        wait_cnt(1, 1, 60);
        ch(32'(top_n), 32'(top_seen), "watchdog count raised interrupt");
        // Second reset with the strap low forces the watchdog
        presetn <= 1'b0;
        strap <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        xfer(TWD_OFS_STAT, 1'b0, 32'h0);
        ch({30'h0, rd[1:0]}, 32'h3, "strap did not force watchdog");
        complete_run();
    end
endmodule
`default_nettype wire
